// ### hw/fpxr_exc_logic.sv
// Exception detection and special-result selection around the FP arithmetic core
//
// Notes on behaviour
// - Rounded result too big raises overflow
// - Overflow gives largest normal or infinity per rounding
// - Float-to-integer out of range raises overflow
// - Tiny nonzero result raises underflow, gives zero
// - Exactly zero result never raises underflow
// - Normal over zero: divide-by-zero, signed infinity
// - Any NaN operand, except in compare: invalid flag, NaN result
// - Inf*0, 0/0, inf/inf, inf-inf are invalid
// - Invalid result is positive all-ones NaN
// - Always flush denormals and tiny outputs to zero
// - Like-signed infinities add; infinity absorbs finite
// - Opposite infinities summed give NaN, invalid
// - Zero sum sign: same keeps, mixed per mode
// - Clean combinations raise no flag at all
// - Compare outcome goes to condition code field
// - Unordered on NaN; denormals equal zero
// - Same-sign normals compare by numeric order
// - Lost low bits before rounding set precision
// - Enabled exception raises interrupt to host
//
// Core math is outside; this block patches its result
`timescale 1ns/1ps
`include "fpxr_consts.svh"

module fpxr_exc_logic
  import fpxr_pkg::*;
(
  input wire logic mclk, // 20 MHz coprocessor clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic op_valid, // One-cycle pulse: operation issued
  input wire fpxr_op_t op_code, // Operation kind
  input wire logic op_double, // High for double precision, low for single
  input wire fpxr_rmode_t round_mode, // Rounding mode for this operation
  input wire logic [63:0] src1, // Source1 operand (single in low word)
  input wire logic [63:0] src2, // Source2 operand (single in low word)
  input wire logic [63:0] core_result, // Rounded result from arithmetic core
  input wire logic core_overflow, // Core: rounded magnitude above largest normal
  input wire logic core_tiny, // Core: rounded nonzero result below min normal
  input wire logic core_zero, // Core: true result exactly zero
  input wire logic core_inexact, // Core: nonzero bits below result LSB
  input wire logic core_int_overflow, // Core: float-to-integer out of 32-bit range
  input wire logic [4:0] exc_enable, // Exception enables, one per flag
  input wire logic [4:0] exc_clear, // Pulse per flag: clear accumulated bit
  output logic [63:0] result_reg, // Final result
  output logic result_valid_reg, // One-cycle pulse, result and flags ready
  output logic [4:0] op_flags_reg, // Flags raised by the last operation
  output logic [4:0] accum_flags_reg, // Accumulated exception field
  output logic [1:0] cond_code_reg, // Condition code field of processor_control_register
  output logic exc_irq // Level: an enabled accumulated exception is set
);

  // Classify an operand; denormals are reported so callers can flush them
  function automatic fpxr_class_t classify(input logic [63:0] x, input logic dbl);
    logic exp_zero;
    logic exp_ones;
    logic frac_zero;
    exp_zero = dbl ? (x[62:52] == 11'h000) : (x[30:23] == 8'h00);
    exp_ones = dbl ? (x[62:52] == `FPXR_D_EXP_ONES) : (x[30:23] == `FPXR_S_EXP_ONES);
    frac_zero = dbl ? (x[51:0] == 52'h0) : (x[22:0] == 23'h0);
    if (exp_ones) begin
      // Infinity or NaN
      classify = frac_zero ? FPXR_INF : FPXR_NAN;
    end else if (exp_zero) begin
      // Zero or denormal
      classify = frac_zero ? FPXR_ZERO : FPXR_DENORMAL_OPERAND;
    end else begin
      // Normal number
      classify = FPXR_NRM;
    end
  endfunction

  // Sign bit of an operand in the chosen format
  function automatic logic sign_of(input logic [63:0] x, input logic dbl);
    sign_of = dbl ? x[63] : x[31];
  endfunction

  // Magnitude bits of an operand, sign removed, right aligned
  function automatic logic [62:0] mag_of(input logic [63:0] x, input logic dbl);
    mag_of = dbl ? x[62:0] : {32'h0, x[30:0]};
  endfunction

  // Signed zero in the chosen format
  function automatic logic [63:0] zero_val(input logic s, input logic dbl);
    zero_val = dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
  endfunction

  // Signed infinity in the chosen format
  function automatic logic [63:0] inf_val(input logic s, input logic dbl);
    inf_val = dbl ? {s, `FPXR_D_INF} : {32'h0, s, `FPXR_S_INF};
  endfunction

  // Default NaN: sign clear, exponent and fraction all ones
  function automatic logic [63:0] nan_val(input logic dbl);
    nan_val = dbl ? `FPXR_D_NAN : {32'h0, `FPXR_S_NAN};
  endfunction

  // Overflow result: toward zero, or toward the infinity opposite the sign, clamps to largest normal instead of infinity
  function automatic logic [63:0] ovf_val(input logic s, input logic dbl, input fpxr_rmode_t rm);
    logic clamp;
    clamp = s ? (rm == round_toward_plus || rm == round_toward_zero)
              : (rm == round_toward_minus || rm == round_toward_zero);
    if (clamp) begin
      // Inward rounding stops short
      ovf_val = dbl ? {s, `FPXR_D_MAXNRM} : {32'h0, s, `FPXR_S_MAXNRM};
    end else begin
      // Outward rounding reaches infinity
      ovf_val = inf_val(s, dbl);
    end
  endfunction

  fpxr_class_t cls1; // Class of Source1
  fpxr_class_t cls2; // Class of Source2
  logic s1; // Sign of Source1
  logic s2; // Sign of Source2
  logic s2_eff; // Source2 sign after subtraction negates it
  logic z1; // Source1 zero after flushing
  logic z2; // Source2 zero after flushing
  logic any_nan; // Either operand is a NaN
  logic [63:0] res_next; // Result chosen this cycle
  logic [4:0] flags_next; // Flags raised this cycle
  fpxr_cc_t cc_next; // Compare outcome this cycle
  logic core_sign; // Sign of the core's result

  // Operand decode shared by all operations
  always_comb begin
    cls1 = classify(src1, op_double);
    cls2 = classify(src2, op_double);
    s1 = sign_of(src1, op_double);
    s2 = sign_of(src2, op_double);
    // Subtract negates Source2
    s2_eff = s2 ^ (op_code == FPXR_OP_SUB);
    // Denormal is always zero
    z1 = (cls1 == FPXR_ZERO) || (cls1 == FPXR_DENORMAL_OPERAND);
    z2 = (cls2 == FPXR_ZERO) || (cls2 == FPXR_DENORMAL_OPERAND);
    any_nan = (cls1 == FPXR_NAN) || (cls2 == FPXR_NAN);
    // Core result sign for clamps
    core_sign = sign_of(core_result, op_double);
  end

  // Compare: denormals are flushed, then ordered as sign and magnitude
  always_comb begin
    logic [62:0] m1;
    logic [62:0] m2;
    // Flushed operands are zero
    m1 = z1 ? 63'h0 : mag_of(src1, op_double);
    m2 = z2 ? 63'h0 : mag_of(src2, op_double);
    // NaN: unordered
    if (any_nan) begin
      cc_next = FPXR_CC_UN;
    end else if (z1 && z2) begin
      cc_next = FPXR_CC_EQ;
    end else if (z1) begin
      // Zero against nonzero: Source2's sign decides
      cc_next = s2 ? FPXR_CC_GT : FPXR_CC_LT;
    end else if (z2) begin
      // Source1's sign decides
      cc_next = s1 ? FPXR_CC_LT : FPXR_CC_GT;
    end else if (s1 != s2) begin
      // Negative side is smaller
      cc_next = s1 ? FPXR_CC_LT : FPXR_CC_GT;
    end else if (m1 == m2) begin
      // Like infinities too
      cc_next = FPXR_CC_EQ;
    end else if ((m1 < m2) ^ s1) begin
      // Larger magnitude is smaller when both negative
      cc_next = FPXR_CC_LT;
    end else begin
      cc_next = FPXR_CC_GT;
    end
  end

  // Special-case selection; finite nonzero cases take the core's rounded result
  always_comb begin
    logic use_core;
    use_core = 1'b0;
    res_next = core_result;
    flags_next = 5'h00;

    case (op_code)
      // Add and subtract
      FPXR_OP_ADD, FPXR_OP_SUB: begin
        if (any_nan) begin
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if (cls1 == FPXR_INF && cls2 == FPXR_INF) begin
          if (s1 == s2_eff) begin
            res_next = inf_val(s1, op_double);
          end else begin
            // Effective subtraction of equal infinities
            res_next = nan_val(op_double);
            flags_next[`FPXR_FLAG_INVALID] = 1'b1;
          end
        end else if (cls1 == FPXR_INF) begin
          res_next = inf_val(s1, op_double);
        end else if (cls2 == FPXR_INF) begin
          // Negated on subtract
          res_next = inf_val(s2_eff, op_double);
        end else if (z1 && z2) begin
          // Mixed-sign zeros give minus zero only when rounding toward minus
          res_next = zero_val((s1 == s2_eff) ? s1 : (round_mode == round_toward_minus), op_double);
        end else if (core_zero) begin
          // Exact cancellation follows the same sign convention, no underflow
          res_next = zero_val(round_mode == round_toward_minus, op_double);
        end else begin
          use_core = 1'b1;
        end
      end

      // Multiply
      FPXR_OP_MUL: begin
        if (any_nan) begin
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if ((cls1 == FPXR_INF && z2) || (z1 && cls2 == FPXR_INF)) begin
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if (cls1 == FPXR_INF || cls2 == FPXR_INF) begin
          // Infinity stays
          res_next = inf_val(s1 ^ s2, op_double);
        end else if (z1 || z2) begin
          // Flushed to zero
          res_next = zero_val(s1 ^ s2, op_double);
        end else begin
          use_core = 1'b1;
        end
      end

      // Divide
      FPXR_OP_DIV: begin
        if (any_nan) begin
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if ((cls1 == FPXR_INF && cls2 == FPXR_INF) || (z1 && z2)) begin
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if (cls1 == FPXR_INF) begin
          res_next = inf_val(s1 ^ s2, op_double);
        end else if (z2) begin
          // Normal dividend over zero or flushed denormal divisor
          res_next = inf_val(s1 ^ s2, op_double);
          flags_next[`FPXR_FLAG_DIVZERO] = 1'b1;
        end else if (z1 || cls2 == FPXR_INF) begin
          // Quotient is zero
          res_next = zero_val(s1 ^ s2, op_double);
        end else begin
          use_core = 1'b1;
        end
      end

      // Float to integer
      FPXR_OP_F2I: begin
        if (cls1 == FPXR_NAN) begin
          // NaN has no integer
          res_next = nan_val(op_double);
          flags_next[`FPXR_FLAG_INVALID] = 1'b1;
        end else if (cls1 == FPXR_INF || core_int_overflow) begin
          // Integer destination cannot hold the value
          flags_next[`FPXR_FLAG_OVERFLOW] = 1'b1;
        end else begin
          flags_next[`FPXR_FLAG_PRECISION] = core_inexact;
        end
      end

      FPXR_OP_CMP: begin
        // Compare leaves the result alone; the condition code moves and the flags clear
        res_next = result_reg;
      end

      // Unknown code
      default: begin
        res_next = result_reg;
      end
    endcase

    // Common tail for results that come through the rounding core
    if (use_core) begin
      flags_next[`FPXR_FLAG_PRECISION] = core_inexact;
      if (core_overflow) begin
        // Beats the tiny check
        res_next = ovf_val(core_sign, op_double, round_mode);
        flags_next[`FPXR_FLAG_OVERFLOW] = 1'b1;
      end else if (core_tiny && !core_zero) begin
        // Tiny outputs are flushed, never delivered as denormals
        res_next = zero_val(core_sign, op_double);
        flags_next[`FPXR_FLAG_UNDERFLOW] = 1'b1;
      end else if (core_zero) begin
        // No underflow on zero
        res_next = zero_val(core_sign, op_double);
      end
    end
  end

  // Result and per-operation flags, registered one cycle after issue
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= `FPXR_RESULT_RST;
      op_flags_reg <= `FPXR_FLAGS_RST;
    end else if (op_valid) begin
      // Held for late reads
      result_reg <= res_next;
      op_flags_reg <= flags_next;
    end
  end

  // Completion strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_valid_reg <= 1'b0;
    end else begin
      // Exactly one edge later
      result_valid_reg <= op_valid;
    end
  end

  // Condition code updates only on compare, so other work cannot disturb it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cond_code_reg <= FPXR_CC_EQ;
    end else if (op_valid && op_code == FPXR_OP_CMP) begin
      // Only compare writes here
      cond_code_reg <= cc_next;
    end
  end

  // Accumulated field: a flag raised in the clearing cycle survives the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accum_flags_reg <= `FPXR_FLAGS_RST;
    end else begin
      // Set beats clear: no lost event
      accum_flags_reg <= (accum_flags_reg & ~exc_clear) | (op_valid ? flags_next : 5'h00);
    end
  end

  // Interrupt request held while any enabled accumulated flag is set
  // Level until software clears
  assign exc_irq = |(accum_flags_reg & exc_enable);

endmodule

// ### shared/fpxr_consts.svh
// Constants for the floating-point exception and special-result logic
`ifndef FPXR_CONSTS_SVH
`define FPXR_CONSTS_SVH

// Exception flag bit positions in the per-operation and accumulated fields
`define FPXR_FLAG_INVALID 0
`define FPXR_FLAG_DIVZERO 1
`define FPXR_FLAG_OVERFLOW 2
`define FPXR_FLAG_UNDERFLOW 3
`define FPXR_FLAG_PRECISION 4
`define FPXR_FLAG_W 5

// Reset values
`define FPXR_FLAGS_RST 5'h00
`define FPXR_RESULT_RST 64'h0000_0000_0000_0000

// Single-precision special encodings (low word of the result bus)
`define FPXR_S_INF 31'h7f80_0000
`define FPXR_S_MAXNRM 31'h7f7f_ffff
`define FPXR_S_NAN 32'h7fff_ffff

// Double-precision special encodings
`define FPXR_D_INF 63'h7ff0_0000_0000_0000
`define FPXR_D_MAXNRM 63'h7fef_ffff_ffff_ffff
`define FPXR_D_NAN 64'h7fff_ffff_ffff_ffff

// Exponent all-ones patterns
`define FPXR_S_EXP_ONES 8'hff
`define FPXR_D_EXP_ONES 11'h7ff

`endif

// ### shared/fpxr_pkg.sv
// Types for the floating-point exception and special-result logic
package fpxr_pkg;

  // Operation requested of the datapath
  typedef enum logic [2:0] {
    FPXR_OP_ADD,
    FPXR_OP_SUB,
    FPXR_OP_MUL,
    FPXR_OP_DIV,
    FPXR_OP_CMP,
    FPXR_OP_F2I
  } fpxr_op_t;

  // Rounding modes
  typedef enum logic [1:0] {
    round_nearest_even = 2'h0,
    round_toward_zero = 2'h1,
    round_toward_plus = 2'h2,
    round_toward_minus = 2'h3
  } fpxr_rmode_t;

  // Operand classes
  typedef enum logic [2:0] {
    FPXR_ZERO,
    FPXR_DENORMAL_OPERAND,
    FPXR_NRM,
    FPXR_INF,
    FPXR_NAN
  } fpxr_class_t;

  // Compare outcome codes for the condition code field
  typedef enum logic [1:0] {
    FPXR_CC_EQ = 2'h0,
    FPXR_CC_LT = 2'h1,
    FPXR_CC_GT = 2'h2,
    FPXR_CC_UN = 2'h3
  } fpxr_cc_t;

endpackage

// ### sim/fpxr_exc_logic_checker.sv
// Concurrent checks on the ports of the FP exception logic
`timescale 1ns/1ps
`include "fpxr_consts.svh"
module fpxr_exc_logic_checker
  import fpxr_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic op_valid, // Issue strobe
  input wire fpxr_op_t op_code, // Operation
  input wire logic op_double, // Precision select
  input wire fpxr_rmode_t round_mode, // Rounding mode
  input wire logic [63:0] src1, // Operand 1
  input wire logic [63:0] src2, // Operand 2
  input wire logic [63:0] core_result, // Core result
  input wire logic core_overflow, // Core overflow
  input wire logic core_tiny, // Core tiny
  input wire logic core_zero, // Core exact zero
  input wire logic core_inexact, // Core inexact
  input wire logic core_int_overflow, // Core integer overflow
  input wire logic [4:0] exc_enable, // Enables
  input wire logic [4:0] exc_clear, // Clears
  input wire logic [63:0] result_reg, // Result
  input wire logic result_valid_reg, // Result strobe
  input wire logic [4:0] op_flags_reg, // Last-op flags
  input wire logic [4:0] accum_flags_reg, // Accumulated flags
  input wire logic [1:0] cond_code_reg, // Condition code
  input wire logic exc_irq // Interrupt level
);
  // One clock domain, so one default clock and reset
  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_valid_lat; op_valid |=> result_valid_reg; endproperty
  a_valid_lat: assert property (p_valid_lat) else $error("result strobe missing");
  property p_valid_pulse; !op_valid |=> !result_valid_reg; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe without issue");
  property p_irq; exc_irq == |(accum_flags_reg & exc_enable); endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_accum_set; op_valid |=> (accum_flags_reg & op_flags_reg) == op_flags_reg; endproperty
  a_accum_set: assert property (p_accum_set) else $error("raised flag not accumulated");
  property p_accum_hold; (!op_valid && exc_clear == 5'h00) |=> $stable(accum_flags_reg); endproperty
  a_accum_hold: assert property (p_accum_hold) else $error("accumulated field moved");
  property p_accum_clr; (!op_valid && exc_clear != 5'h00) |=> (accum_flags_reg & $past(exc_clear)) == 5'h00; endproperty
  a_accum_clr: assert property (p_accum_clr) else $error("accumulated bit not cleared");
  // Invalid arithmetic must give the positive all-ones NaN of its width
  property p_nan_res;
    op_valid && (op_code inside {FPXR_OP_ADD, FPXR_OP_SUB, FPXR_OP_MUL, FPXR_OP_DIV}) ##1 op_flags_reg[0]
      |-> result_reg == ($past(op_double) ? `FPXR_D_NAN : {32'h0000_0000, `FPXR_S_NAN}); endproperty
  a_nan_res: assert property (p_nan_res) else $error("invalid result not default NaN");
  // Toward-zero overflow clamps to the largest normal
  property p_ovf_rz;
    op_valid && op_code == FPXR_OP_ADD && !op_double && round_mode == round_toward_zero ##1 op_flags_reg[2]
      |-> result_reg[30:0] == `FPXR_S_MAXNRM; endproperty
  a_ovf_rz: assert property (p_ovf_rz) else $error("overflow clamp wrong");
  property p_cmp; op_valid && op_code == FPXR_OP_CMP |=> op_flags_reg == 5'h00 && $stable(result_reg); endproperty
  a_cmp: assert property (p_cmp) else $error("compare touched result or flags");
  property p_cc_hold; !(op_valid && op_code == FPXR_OP_CMP) |=> $stable(cond_code_reg); endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("condition code moved");
  property p_idle; !op_valid |=> $stable(op_flags_reg) && $stable(result_reg); endproperty
  a_idle: assert property (p_idle) else $error("outputs moved while idle");
endmodule

bind fpxr_exc_logic fpxr_exc_logic_checker u_fpxr_exc_logic_checker (.mclk(mclk), .nrst(nrst),
  .op_valid(op_valid), .op_code(op_code), .op_double(op_double), .round_mode(round_mode), .src1(src1),
  .src2(src2), .core_result(core_result), .core_overflow(core_overflow), .core_tiny(core_tiny),
  .core_zero(core_zero), .core_inexact(core_inexact), .core_int_overflow(core_int_overflow),
  .exc_enable(exc_enable), .exc_clear(exc_clear), .result_reg(result_reg), .result_valid_reg(result_valid_reg),
  .op_flags_reg(op_flags_reg), .accum_flags_reg(accum_flags_reg), .cond_code_reg(cond_code_reg), .exc_irq(exc_irq));

// ### sim/fpxr_host_model.sv
// Host and core model that issues operations to the exception logic
`timescale 1ns/1ps
module fpxr_host_model
  import fpxr_pkg::*;
(
  input wire logic mclk, // Clock
  output logic op_valid, // Issue strobe
  output fpxr_op_t op_code, // Operation
  output logic op_double, // Precision select
  output fpxr_rmode_t round_mode, // Rounding mode
  output logic [63:0] src1, // Operand 1
  output logic [63:0] src2, // Operand 2
  output logic [63:0] core_result, // Core result
  output logic [4:0] core_bits // Core status: ovf, tiny, zero, inexact, int ovf
);
  // Quiet bus at time zero
  initial begin
    op_valid = 1'b0;
    op_code = FPXR_OP_ADD;
    op_double = 1'b0;
    round_mode = round_nearest_even;
    src1 = 64'h0;
    src2 = 64'h0;
    core_result = 64'h0;
    core_bits = 5'h00;
  end
  // Present one operation; caller either issues again or idles next edge
  task automatic issue(input fpxr_op_t o, input logic d, input fpxr_rmode_t m,
    input logic [63:0] a, input logic [63:0] b, input logic [63:0] r, input logic [4:0] c);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= o;
    op_double <= d;
    round_mode <= m;
    src1 <= a;
    src2 <= b;
    core_result <= r;
    core_bits <= c;
  endtask
  // Drop the strobe; operands are scrambled so stale values are never relied on
  task automatic idle();
    @(posedge mclk);
    op_valid <= 1'b0;
    src1 <= ~src1;
    src2 <= ~src2;
    core_result <= ~core_result;
  endtask
endmodule

// ### sim/tb_fpxr_exc_logic.sv
// Self-checking testbench for the FP exception logic
`timescale 1ns/1ps
module tb_fpxr_exc_logic;
  import fpxr_pkg::*;
  typedef struct { fpxr_op_t o; int m; logic [31:0] a, b, r; int c; logic [31:0] er; int ef, ec; } fpxr_row_t;
  localparam logic [31:0] z = 32'h0000_0000, nz = 32'h8000_0000, dn = 32'h0000_0001, one = 32'h3f80_0000;
  localparam logic [31:0] mone = 32'hbf80_0000, two = 32'h4000_0000, mtwo = 32'hc000_0000, inf = 32'h7f80_0000;
  localparam logic [31:0] ninf = 32'hff80_0000, qnan = 32'h7fc0_0000, dnan = 32'h7fff_ffff;
  localparam logic [31:0] mx = 32'h7f7f_ffff, nmx = 32'hff7f_ffff;
  localparam fpxr_op_t o_add = FPXR_OP_ADD, o_sub = FPXR_OP_SUB, o_mul = FPXR_OP_MUL;
  localparam fpxr_op_t o_div = FPXR_OP_DIV, o_cmp = FPXR_OP_CMP, o_f2i = FPXR_OP_F2I;
  logic mclk = 1'b0; // Clock
  logic nrst = 1'b0; // Reset
  logic op_valid, op_double; // Issue strobe, precision
  fpxr_op_t op_code; // Operation
  fpxr_rmode_t round_mode; // Rounding
  logic [63:0] src1, src2, core_result, result_reg; // Data
  logic [4:0] core_bits, op_flags_reg, accum_flags_reg; // Status
  logic [4:0] exc_enable = 5'h00, exc_clear = 5'h00; // Controls
  logic result_valid_reg, exc_irq; // Strobes
  logic [1:0] cond_code_reg; // Condition code
  int bad_count = 0, checked = 0; // Tallies
  fpxr_row_t rows[$]; // Ordinary cases

  always #25 mclk = ~mclk; // 20 MHz
  fpxr_host_model u_fpxr_host_model (.mclk(mclk), .op_valid(op_valid), .op_code(op_code), .op_double(op_double),
    .round_mode(round_mode), .src1(src1), .src2(src2), .core_result(core_result), .core_bits(core_bits));
  fpxr_exc_logic u_fpxr_exc_logic (.mclk(mclk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .op_double(op_double), .round_mode(round_mode), .src1(src1), .src2(src2), .core_result(core_result),
    .core_overflow(core_bits[0]), .core_tiny(core_bits[1]), .core_zero(core_bits[2]),
    .core_inexact(core_bits[3]), .core_int_overflow(core_bits[4]), .exc_enable(exc_enable),
    .exc_clear(exc_clear), .result_reg(result_reg), .result_valid_reg(result_valid_reg),
    .op_flags_reg(op_flags_reg), .accum_flags_reg(accum_flags_reg), .cond_code_reg(cond_code_reg),
    .exc_irq(exc_irq));

  // Value compare; case inequality so an unknown never matches
  task automatic cmp_val(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic add(input fpxr_op_t o, input int m, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] r, input int c, input logic [31:0] er, input int ef, input int ec);
    rows.push_back('{o, m, a, b, r, c, er, ef, ec});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bounded run: far more cycles than the sequence needs
  initial begin
    repeat (2000) @(posedge mclk);
    bad_count++;
    close_out();
  end

  initial begin
    add(o_add, 0, one, one, two, 0, two, 0, 0);
    add(o_add, 0, inf, inf, z, 0, inf, 0, 0);
    add(o_add, 0, ninf, ninf, z, 0, ninf, 0, 0);
    add(o_add, 0, inf, one, z, 0, inf, 0, 0);
    add(o_sub, 0, inf, inf, z, 0, dnan, 1, 0);
    add(o_add, 0, inf, ninf, z, 0, dnan, 1, 0);
    add(o_add, 0, qnan, one, z, 0, dnan, 1, 0);
    add(o_sub, 0, one, qnan, z, 0, dnan, 1, 0);
    add(o_div, 0, qnan, z, z, 0, dnan, 1, 0);
    add(o_add, 1, one, one, inf, 1, mx, 4, 0);
    add(o_add, 0, one, one, inf, 1, inf, 4, 0);
    add(o_add, 2, mone, mone, ninf, 1, nmx, 4, 0);
    add(o_add, 3, mone, mone, ninf, 1, ninf, 4, 0);
    add(o_add, 0, one, mone, dn, 2, z, 8, 0);
    add(o_add, 3, one, mone, z, 4, nz, 0, 0);
    add(o_add, 0, one, one, two, 8, two, 16, 0);
    add(o_div, 0, one, z, z, 0, inf, 2, 0);
    add(o_div, 0, mone, dn, z, 0, ninf, 2, 0);
    add(o_div, 0, z, dn, z, 0, dnan, 1, 0);
    add(o_div, 0, inf, ninf, z, 0, dnan, 1, 0);
    add(o_mul, 0, inf, z, z, 0, dnan, 1, 0);
    add(o_div, 0, dn, one, z, 0, z, 0, 0);
    add(o_div, 0, one, inf, z, 0, z, 0, 0);
    add(o_div, 0, inf, z, z, 0, inf, 0, 0);
    add(o_add, 3, z, z, z, 0, z, 0, 0);
    add(o_add, 0, nz, nz, z, 0, nz, 0, 0);
    add(o_add, 2, z, nz, z, 0, z, 0, 0);
    add(o_add, 3, nz, z, z, 0, nz, 0, 0);
    add(o_f2i, 0, two, z, dnan, 16, dnan, 4, 0);
    add(o_cmp, 0, qnan, one, z, 0, z, 0, 3);
    add(o_cmp, 0, one, two, z, 0, z, 0, 1);
    add(o_cmp, 0, two, one, z, 0, z, 0, 2);
    add(o_cmp, 0, mone, mtwo, z, 0, z, 0, 2);
    add(o_cmp, 0, dn, nz, z, 0, z, 0, 0);
    add(o_cmp, 0, inf, inf, z, 0, z, 0, 0);
    add(o_cmp, 0, ninf, dn, z, 0, z, 0, 1);
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    // Table walk: one issue, one idle edge, then judge the registered outputs
    foreach (rows[i]) begin
      u_fpxr_host_model.issue(rows[i].o, 1'b0, fpxr_rmode_t'(2'(rows[i].m)), {32'h0, rows[i].a},
        {32'h0, rows[i].b}, {32'h0, rows[i].r}, 5'(rows[i].c));
      u_fpxr_host_model.idle();
      #1;
      cmp_bit("valid", 1'b1, result_valid_reg);
      cmp_val("flags", 64'(rows[i].ef), 64'(op_flags_reg));
      if (rows[i].o == o_cmp) begin
        cmp_val("cc", 64'(rows[i].ec), 64'(cond_code_reg));
      end else begin
        cmp_val("result", {32'h0, rows[i].er}, result_reg);
      end
    end
    $display("table test done");
    // Accumulation, interrupt, and set winning over clear
    cmp_val("accum", 64'h1f, 64'(accum_flags_reg));
    @(posedge mclk);
    exc_enable <= 5'h04;
    #1;
    cmp_bit("irq", 1'b1, exc_irq);
    u_fpxr_host_model.issue(o_add, 1'b0, round_nearest_even, {32'h0, qnan}, {32'h0, one}, 64'h0, 5'h00);
    exc_clear <= 5'h1f;
    u_fpxr_host_model.idle();
    exc_clear <= 5'h00;
    #1;
    cmp_val("accum", 64'h01, 64'(accum_flags_reg));
    cmp_bit("irq", 1'b0, exc_irq);
    @(posedge mclk);
    exc_clear <= 5'h01;
    @(posedge mclk);
    exc_clear <= 5'h00;
    #1;
    cmp_val("accum", 64'h00, 64'(accum_flags_reg));
    $display("accumulate test done");
    // Back-to-back issues, then double precision specials
    u_fpxr_host_model.issue(o_div, 1'b0, round_nearest_even, {32'h0, one}, 64'h0, 64'h0, 5'h00);
    u_fpxr_host_model.issue(o_add, 1'b0, round_nearest_even, {32'h0, qnan}, {32'h0, one}, 64'h0, 5'h00);
    #1;
    cmp_val("flags", 64'h02, 64'(op_flags_reg));
    u_fpxr_host_model.issue(o_add, 1'b1, round_nearest_even, 64'h7ff8_0000_0000_0000, 64'h3ff0_0000_0000_0000,
      64'h0, 5'h00);
    #1;
    cmp_val("flags", 64'h01, 64'(op_flags_reg));
    u_fpxr_host_model.issue(o_add, 1'b1, round_toward_zero, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000,
      64'h7ff0_0000_0000_0000, 5'h01);
    #1;
    cmp_val("result", 64'h7fff_ffff_ffff_ffff, result_reg);
    u_fpxr_host_model.idle();
    #1;
    cmp_val("result", 64'h7fef_ffff_ffff_ffff, result_reg);
    cmp_val("accum", 64'h07, 64'(accum_flags_reg));
    $display("back-to-back test done");
    // Reset in mid-run clears every register
    @(posedge mclk);
    nrst <= 1'b0;
    #1;
    cmp_val("accum", 64'h00, 64'(accum_flags_reg));
    cmp_val("result", 64'h0, result_reg);
    cmp_val("cc", 64'h0, 64'(cond_code_reg));
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    // First edge after release is idle, the second takes an issue
    u_fpxr_host_model.issue(o_div, 1'b0, round_nearest_even, {32'h0, one}, 64'h0, 64'h0, 5'h00);
    #1;
    cmp_bit("valid", 1'b0, result_valid_reg);
    u_fpxr_host_model.idle();
    #1;
    cmp_val("flags", 64'h02, 64'(op_flags_reg));
    cmp_val("accum", 64'h02, 64'(accum_flags_reg));
    $display("reset test done");
    close_out();
  end
endmodule
